// [logic/thcs_seq.sv]
// Cut-cycle sequencer of a plasma torch height controller
//
// Our own choices: the register addresses and the Avalon-MM register port.
`include "thcs_cfg.svh"
`default_nettype none
module thcs_seq
   import thcs_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Avalon-MM slave
   input  wire logic [5:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   // Pins from CNC, plasma supply and panel
   input  wire logic        cycle_start_i,
   input  wire logic        height_loop_inhibit_i,
   input  wire logic        arc_transfer_input_i,
   input  wire logic        tip_contact_i,
   input  wire logic        man_up_i,
   input  wire logic        man_down_i,
   // Lifter position and arc voltage
   input  wire logic [15:0] lift_pos_i,
   input  wire logic [11:0] arc_volt_i,
   // Outputs
   output logic             plasma_start_o,
   output logic             motion_permit_o,
   output thcs_drive_t      drive_o,
   output logic [10:0]      state_o
);
   ///////////////////////////////////////////////////////////////////////////
   localparam int JOG_WAIT = `THCS_JOG_WAIT_CYC;
   localparam int JOG_FAST = `THCS_JOG_FAST_CYC;
   localparam int TENTH    = `THCS_TENTH_CYC;

   // Pin synchronisers, two flops each
   logic [5:0] sync1;
   logic [5:0] sync2;
   always_ff @(posedge clk_i) begin
      sync1 <= {cycle_start_i, height_loop_inhibit_i, arc_transfer_input_i,
                tip_contact_i, man_up_i, man_down_i};
      sync2 <= sync1;
   end
   wire logic cyc_s  = sync2[5];
   wire logic inh_s  = sync2[4];
   wire logic arc_s  = sync2[3];
   wire logic tip_s  = sync2[2];
   wire logic up_s   = sync2[1];
   wire logic dn_s   = sync2[0];

   ///////////////////////////////////////////////////////////////////////////
   // Configuration registers
   logic [2:0]  ctrl;
   logic [15:0] cut_h;
   logic [15:0] xfer_h;
   logic [15:0] pierce_h;
   logic [15:0] retr_h;
   logic [15:0] pierce_t;
   logic [7:0]  avc_dly;
   logic [11:0] setpt;
   logic [4:0]  lock_pct;
   logic        xfer_set;

   wire logic wr = avs_write_i && !avs_waitrequest_o;
   wire logic [15:0] cut_150 = avs_writedata_i[15:0] + {1'b0, avs_writedata_i[15:1]};
   wire logic [7:0]  avc_clip = (avs_writedata_i[7:0] > `THCS_AVC_MAX_TENTH) ?
                                `THCS_AVC_MAX_TENTH : avs_writedata_i[7:0];

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl     <= 3'h0;
         cut_h    <= 16'h0000;
         xfer_h   <= 16'h0000;
         pierce_h <= 16'h0000;
         retr_h   <= 16'h0000;
         pierce_t <= 16'h0000;
         avc_dly  <= 8'h00;
         setpt    <= 12'h000;
         lock_pct <= 5'h00;
         xfer_set <= 1'b0;
      end else if (wr) begin
         case (avs_address_i)
            `THCS_REG_CTRL:     ctrl <= avs_writedata_i[2:0];
            `THCS_REG_CUT_H: begin
               cut_h <= avs_writedata_i[15:0];
               if (!xfer_set) begin
                  xfer_h <= cut_150;
               end
            end
            `THCS_REG_XFER_H: begin
               xfer_h   <= avs_writedata_i[15:0];
               xfer_set <= 1'b1;
            end
            `THCS_REG_PIERCE_H: pierce_h <= avs_writedata_i[15:0];
            `THCS_REG_RETR_H:   retr_h <= avs_writedata_i[15:0];
            `THCS_REG_PIERCE_T: pierce_t <= avs_writedata_i[15:0];
            `THCS_REG_AVC_DLY:  avc_dly <= avc_clip;
            `THCS_REG_SETPT:    setpt <= avs_writedata_i[11:0];
            `THCS_REG_LOCK_PCT: lock_pct <= avs_writedata_i[4:0];
            default: ;
         endcase
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Sequencer
   thcs_state_t state;
   thcs_state_t next_state;
   logic [15:0] work_pos;
   logic [11:0] ref_v;
   logic [31:0] tmr;
   logic [15:0] tenths;
   logic [31:0] man_cnt;
   logic [15:0] jog_tgt;
   logic        man_act;
   logic        man_dir_up;
   logic        jog_busy;

   wire logic [15:0] tgt_xfer   = work_pos + xfer_h;
   wire logic [15:0] tgt_pierce = work_pos + pierce_h;
   wire logic [15:0] tgt_cut    = work_pos + cut_h;
   wire logic [15:0] tgt_retr   = work_pos + retr_h;
   wire logic at_xfer   = (lift_pos_i == tgt_xfer);
   wire logic at_pierce = (lift_pos_i == tgt_pierce);
   wire logic at_cut    = (lift_pos_i == tgt_cut);
   wire logic at_retr   = (lift_pos_i == tgt_retr);
   wire logic tick      = (tmr == 32'(TENTH - 1));
   wire logic pierce_done = (pierce_t == 16'h0000) || (tick && (tenths + 16'h0001 >= pierce_t));
   wire logic avc_done  = (avc_dly == 8'h00) || (tick && (tenths + 16'h0001 >= {8'h00, avc_dly}));
   // Lock threshold: ref * (100 + pct) / 100, compared without division
   wire logic [19:0] lhs   = 20'(arc_volt_i) * 20'd100;
   wire logic [19:0] rhs   = 20'(ref_v) * (20'd100 + 20'(lock_pct));
   wire logic lock_hit     = ctrl[`THCS_CTRL_LOCK_EN] && (lhs > rhs);
   wire logic loop_run     = ctrl[`THCS_CTRL_AVC_ON] && !inh_s && !lock_hit;
   wire logic man_req      = up_s ^ dn_s;

   always_comb begin
      next_state = state;
      case (state)
         THCS_IDLE:     if (cyc_s && tip_s) next_state = THCS_CONTACT;
         THCS_CONTACT:  if (!tip_s) next_state = THCS_SENSE_UP;
         THCS_SENSE_UP: if (at_xfer) next_state = THCS_PLASMA;
         THCS_PLASMA:   if (arc_s) next_state = THCS_PIERCE_S;
         THCS_PIERCE_S: if (at_pierce) next_state = THCS_PIERCING;
         THCS_PIERCING: if (pierce_done) next_state = THCS_CUT_PREP;
         THCS_CUT_PREP: if (at_cut) next_state = THCS_AVC_WAIT;
         THCS_AVC_WAIT: if (avc_done) begin
            next_state = ctrl[`THCS_CTRL_SAMPLE] ? THCS_SAMPLE : THCS_CUTTING;
         end
         THCS_SAMPLE:   next_state = THCS_CUTTING;
         THCS_CUTTING:  if (!cyc_s) next_state = THCS_RETRACT;
         THCS_RETRACT:  if (at_retr) next_state = THCS_IDLE;
         default:       next_state = THCS_IDLE;
      endcase
      if (state != THCS_IDLE && state != THCS_RETRACT && !cyc_s) begin
         next_state = THCS_RETRACT;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state    <= THCS_IDLE;
         work_pos <= 16'h0000;
         ref_v    <= 12'h000;
         tmr      <= 32'h0000_0000;
         tenths   <= 16'h0000;
      end else begin
         state <= next_state;
         if (state == THCS_CONTACT && !tip_s) begin
            work_pos <= lift_pos_i;
         end
         if (state == THCS_SAMPLE) begin
            ref_v <= arc_volt_i;
         end else if (state == THCS_AVC_WAIT && avc_done) begin
            ref_v <= setpt;
         end
         if (next_state != state || tick) begin
            tmr <= 32'h0000_0000;
         end else begin
            tmr <= tmr + 32'h0000_0001;
         end
         if (next_state != state) begin
            tenths <= 16'h0000;
         end else if (tick) begin
            tenths <= tenths + 16'h0001;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Manual jog profile
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         man_act    <= 1'b0;
         man_dir_up <= 1'b0;
         man_cnt    <= 32'h0000_0000;
         jog_tgt    <= 16'h0000;
      end else if (man_req && (!man_act || man_dir_up == up_s)) begin
         if (!man_act) begin
            jog_tgt <= up_s ? lift_pos_i + `THCS_JOG_STEPS : lift_pos_i - `THCS_JOG_STEPS;
         end
         man_act    <= 1'b1;
         man_dir_up <= up_s;
         if (man_cnt != 32'(JOG_FAST)) begin
            man_cnt <= man_cnt + 32'h0000_0001;
         end
      end else begin
         man_act <= 1'b0;
         man_cnt <= 32'h0000_0000;
      end
   end

   wire logic man_ok = (state == THCS_IDLE) ||
                       (state == THCS_CUTTING && !ctrl[`THCS_CTRL_AVC_ON]);
   always_ff @(posedge clk_i) jog_busy <= rst_n_i &&
      ((man_req && !man_act) || (jog_busy && man_ok && lift_pos_i != jog_tgt));
   wire logic jog_left = jog_busy && (lift_pos_i != jog_tgt); // A short press still finishes its jog
   wire logic [1:0] man_spd = (man_cnt >= 32'(JOG_FAST)) ? `THCS_SPD_MANUAL : `THCS_SPD_SLOW;
   wire logic man_move = man_ok && (jog_left || (man_act && man_cnt >= 32'(JOG_WAIT)));

   ///////////////////////////////////////////////////////////////////////////
   // Drive selection
   thcs_drive_t next_drive;
   always_comb begin
      next_drive = '{up: 1'b0, down: 1'b0, speed: `THCS_SPD_STOP};
      case (state)
         THCS_CONTACT:  next_drive = '{up: 1'b1, down: 1'b0, speed: `THCS_SPD_SLOW};
         THCS_SENSE_UP: if (!at_xfer) next_drive = '{up: (lift_pos_i < tgt_xfer), down: (lift_pos_i > tgt_xfer),
                                                     speed: `THCS_SPD_AUTO};
         THCS_PIERCE_S: if (!at_pierce) next_drive = '{up: (lift_pos_i < tgt_pierce),
                                                       down: (lift_pos_i > tgt_pierce), speed: `THCS_SPD_AUTO};
         THCS_CUT_PREP: if (!at_cut) next_drive = '{up: (lift_pos_i < tgt_cut), down: (lift_pos_i > tgt_cut),
                                                   speed: `THCS_SPD_AUTO};
         THCS_CUTTING:  if (loop_run && arc_volt_i != ref_v) begin
            next_drive = '{up: (arc_volt_i < ref_v), down: (arc_volt_i > ref_v), speed: `THCS_SPD_AUTO};
         end
         THCS_RETRACT:  if (!at_retr) next_drive = '{up: (lift_pos_i < tgt_retr), down: (lift_pos_i > tgt_retr),
                                                    speed: `THCS_SPD_AUTO};
         default: ;
      endcase
      if (man_move) begin
         next_drive = '{up: man_dir_up, down: !man_dir_up, speed: man_spd};
      end
   end

   // Plasma depends on state only and permit on state and at_cut, so a manual jog leaves them alone
   wire logic next_plasma = (state == THCS_PLASMA) || (state == THCS_PIERCE_S) || (state == THCS_PIERCING) ||
                            (state == THCS_CUT_PREP) || (state == THCS_AVC_WAIT) || (state == THCS_SAMPLE) ||
                            (state == THCS_CUTTING);
   wire logic next_permit = (state == THCS_AVC_WAIT) || (state == THCS_SAMPLE) ||
                            (state == THCS_CUTTING) || (state == THCS_CUT_PREP && at_cut);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         drive_o         <= '{up: 1'b0, down: 1'b0, speed: `THCS_SPD_STOP};
         plasma_start_o  <= 1'b0;
         motion_permit_o <= 1'b0;
         state_o         <= 11'h001;
      end else begin
         drive_o         <= next_drive;
         plasma_start_o  <= next_plasma;
         motion_permit_o <= next_permit;
         state_o         <= state;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Bus reply, one wait cycle on every request
   wire logic [31:0] rd_mux =
      (avs_address_i == `THCS_REG_CTRL)     ? {29'h0, ctrl} :
      (avs_address_i == `THCS_REG_CUT_H)    ? {16'h0, cut_h} :
      (avs_address_i == `THCS_REG_XFER_H)   ? {16'h0, xfer_h} :
      (avs_address_i == `THCS_REG_PIERCE_H) ? {16'h0, pierce_h} :
      (avs_address_i == `THCS_REG_RETR_H)   ? {16'h0, retr_h} :
      (avs_address_i == `THCS_REG_PIERCE_T) ? {16'h0, pierce_t} :
      (avs_address_i == `THCS_REG_AVC_DLY)  ? {24'h0, avc_dly} :
      (avs_address_i == `THCS_REG_SETPT)    ? {20'h0, setpt} :
      (avs_address_i == `THCS_REG_LOCK_PCT) ? {27'h0, lock_pct} :
      (avs_address_i == `THCS_REG_STATUS)   ? {18'h0, lock_hit, man_act, arc_s, state} :
      (avs_address_i == `THCS_REG_POS)      ? {work_pos, lift_pos_i} :
      (avs_address_i == `THCS_REG_REF)      ? {20'h0, ref_v} : 32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
      end else begin
         avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
         avs_readdata_o    <= rd_mux;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   plasma_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state == THCS_PLASMA && !arc_s && cyc_s) |=> state == THCS_PLASMA) else $error("left plasma early");
   contact_latch_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state == THCS_CONTACT && !tip_s && cyc_s) |=> (state == THCS_SENSE_UP && work_pos == $past(lift_pos_i)))
      else $error("contact latch wrong");
   cut_end_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state == THCS_CUTTING && !cyc_s) |=> state == THCS_RETRACT) else $error("no retract");
   retract_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state == THCS_RETRACT && at_retr) |=> state == THCS_IDLE) else $error("no idle");
   permit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state == THCS_CUTTING) |=> motion_permit_o) else $error("permit missing");
   plasma_out_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state == THCS_PLASMA) |=> plasma_start_o) else $error("plasma start missing");
   inhibit_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state == THCS_CUTTING && inh_s && !man_move) |=> !drive_o.up && !drive_o.down)
      else $error("moved under inhibit");
   avc_dir_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state == THCS_CUTTING && loop_run && !man_move && arc_volt_i > ref_v) |=> drive_o.down)
      else $error("wrong loop direction");
   pierce_go_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state == THCS_PIERCE_S && at_pierce && cyc_s) |=> state == THCS_PIERCING) else $error("pierce stuck");
endmodule
`default_nettype wire

// [logic/thcs_cfg.svh]
// Constants for the torch height cut sequencer
`ifndef THCS_CFG_SVH
`define THCS_CFG_SVH
`define THCS_CLK_HZ        20000000
`define THCS_JOG_WAIT_MS   500
`define THCS_JOG_FAST_MS   1500
`define THCS_JOG_WAIT_CYC  ((`THCS_CLK_HZ / 1000) * `THCS_JOG_WAIT_MS)
`define THCS_JOG_FAST_CYC  ((`THCS_CLK_HZ / 1000) * `THCS_JOG_FAST_MS)
`define THCS_TENTH_CYC     (`THCS_CLK_HZ / 10)
`define THCS_AVC_MAX_TENTH 8'h64
`define THCS_JOG_STEPS     16'h0019
`define THCS_POS_W         16
`define THCS_VOLT_W        12
// Register offsets (byte addresses)
`define THCS_REG_CTRL      6'h00
`define THCS_REG_CUT_H     6'h04
`define THCS_REG_XFER_H    6'h08
`define THCS_REG_PIERCE_H  6'h0C
`define THCS_REG_RETR_H    6'h10
`define THCS_REG_PIERCE_T  6'h14
`define THCS_REG_AVC_DLY   6'h18
`define THCS_REG_SETPT     6'h1C
`define THCS_REG_LOCK_PCT  6'h20
`define THCS_REG_STATUS    6'h24
`define THCS_REG_POS       6'h28
`define THCS_REG_REF       6'h2C
// CTRL bits
`define THCS_CTRL_AVC_ON   0
`define THCS_CTRL_SAMPLE   1
`define THCS_CTRL_LOCK_EN  2
// Speed codes on the lifter drive
`define THCS_SPD_STOP      2'h0
`define THCS_SPD_SLOW      2'h1
`define THCS_SPD_AUTO      2'h2
`define THCS_SPD_MANUAL    2'h3
`endif

// [logic/thcs_pkg.sv]
// Types for the torch height cut sequencer
`default_nettype none
package thcs_pkg;
   typedef enum logic [10:0] {
      THCS_IDLE     = 11'h001,
      THCS_CONTACT  = 11'h002,
      THCS_SENSE_UP = 11'h004,
      THCS_PLASMA   = 11'h008,
      THCS_PIERCE_S = 11'h010,
      THCS_PIERCING = 11'h020,
      THCS_CUT_PREP = 11'h040,
      THCS_AVC_WAIT = 11'h080,
      THCS_SAMPLE   = 11'h100,
      THCS_CUTTING  = 11'h200,
      THCS_RETRACT  = 11'h400
   } thcs_state_t;
   typedef struct packed {
      logic       up;
      logic       down;
      logic [1:0] speed;
   } thcs_drive_t;
endpackage
`default_nettype wire

// [tb/thcs_plant.sv]
// Lifter, tip sensor and plasma supply model
`include "thcs_cfg.svh"
`default_nettype none
module thcs_plant
   import thcs_pkg::*;
(
   // Sequencer side
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire thcs_drive_t drive_i,
   input  wire logic        plasma_start_i,
   // Scenario controls
   input  wire logic [15:0] plate_i,
   input  wire logic        park_i,
   input  wire logic [7:0]  arc_dly_i,
   input  wire logic [11:0] offs_i,
   // Back to the sequencer
   output logic [15:0]      pos_o,
   output logic             tip_o,
   output logic             arc_o,
   output logic [11:0]      volt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;
   logic [7:0] arc_cnt;
   // Steps at least 4 cycles apart, so a late stop never overruns a target
   wire logic [3:0]  period = (drive_i.speed == `THCS_SPD_SLOW) ? 4'hF : 4'h3;
   wire logic        move = (drive_i.speed != `THCS_SPD_STOP) && (drive_i.up != drive_i.down);
   wire logic [15:0] gap = pos_o - plate_i;
   assign tip_o = (pos_o <= plate_i);
   assign volt_o = arc_o ? 12'h064 + 12'(gap * 16'h0005) + offs_i : 12'h000;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || park_i) begin
         pos_o <= plate_i;
         cnt <= 4'h0;
      end else if (!move || cnt != period) begin
         cnt <= move ? cnt + 4'h1 : 4'h0;
      end else begin
         cnt <= 4'h0;
         if (drive_i.up) begin
            pos_o <= pos_o + 16'h0001;
         end else if (pos_o > plate_i) begin
            pos_o <= pos_o - 16'h0001;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Arc follows plasma start after a set delay and drops with it
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !plasma_start_i) begin
         arc_cnt <= 8'h00;
         arc_o <= 1'b0;
      end else if (arc_cnt != arc_dly_i) begin
         arc_cnt <= arc_cnt + 8'h01;
      end else begin
         arc_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// [tb/thcs_seq_tb.sv]
// Self-checking bench of the torch height cut sequencer
`include "thcs_cfg.svh"
`default_nettype none
module thcs_seq_tb
   import thcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [10:0] st; int pos;} thcs_exp_t;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [5:0]  addr = 6'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic        cyc = 1'b0;
   logic        inh = 1'b0;
   logic        m_up = 1'b0;
   logic        m_dn = 1'b0;
   logic        park = 1'b1;
   logic [15:0] plate = 16'h0200;
   logic [7:0]  arc_dly = 8'h14;
   logic [11:0] offs = 12'h000;
   logic [31:0] rdata;
   logic        wait_r, tip, arc, p_start, permit;
   logic [15:0] pos;
   logic [11:0] volt;
   logic [10:0] state;
   logic [10:0] last = 11'h001;
   thcs_drive_t drive;
   int          miscompares = 0;
   int          samples_checked = 0;
   int          work, p, setpt;
   thcs_exp_t   exp_q[$];
   logic [31:0] dly[4] = '{32'hC8, 32'h64, 32'h65, 32'h00};
   logic [10:0] seq_st[7] = '{THCS_CONTACT, THCS_SENSE_UP, THCS_PLASMA, THCS_PIERCE_S, THCS_PIERCING,
                             THCS_CUT_PREP, THCS_AVC_WAIT};
   int          seq_off[7] = '{-1, 0, 30, 30, 40, 40, 20};

   thcs_seq thcs_seq_inst (.clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r),
      .cycle_start_i(cyc), .height_loop_inhibit_i(inh), .arc_transfer_input_i(arc), .tip_contact_i(tip),
      .man_up_i(m_up), .man_down_i(m_dn), .lift_pos_i(pos), .arc_volt_i(volt), .plasma_start_o(p_start),
      .motion_permit_o(permit), .drive_o(drive), .state_o(state));
   thcs_plant thcs_plant_inst (.clk_i(clk), .rst_n_i(rst_n), .drive_i(drive), .plasma_start_i(p_start),
      .plate_i(plate), .park_i(park), .arc_dly_i(arc_dly), .offs_i(offs), .pos_o(pos), .tip_o(tip),
      .arc_o(arc), .volt_o(volt));

   initial begin
      forever #25 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic check_sig(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic bus_write(input logic [5:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      do @(posedge clk); while (wait_r !== 1'b0);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic check_reg(input string name, input logic [5:0] a, input logic [31:0] exp);
      addr <= a;
      rd <= 1'b1;
      do @(posedge clk); while (wait_r !== 1'b0);
      rd <= 1'b0;
      check_sig(name, exp, rdata);
      @(posedge clk);
   endtask
   // Returns two edges after entry, once registered outputs have caught up
   task automatic wait_state(input logic [10:0] st);
      int n;
      n = 0;
      while (state !== st && n < 20000) begin
         @(posedge clk);
         n++;
      end
      if (n == 20000) check_sig("wait_state", 32'(st), 32'(state));
      repeat (2) @(posedge clk);
   endtask
   task automatic wait_move(input logic dn);
      int n;
      n = 0;
      while ((dn ? drive.down : drive.up) !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      check_sig("drive_dir", 32'h1, 32'(dn ? drive.down : drive.up));
      // Let the loop reach its balance before the next step changes the voltage
      repeat (40) @(posedge clk);
   endtask
   task automatic check_hold;
      repeat (8) @(posedge clk);
      p = pos;
      repeat (20) @(posedge clk);
      check_sig("hold_pos", 32'(p), 32'(pos));
      check_sig("hold_drive", 32'h0, 32'({drive.up, drive.down}));
   endtask
   task automatic jog(input logic dn);
      int p0;
      p0 = pos;
      if (dn) m_dn <= 1'b1; else m_up <= 1'b1;
      repeat (300) @(posedge clk);
      m_up <= 1'b0;
      m_dn <= 1'b0;
      repeat (600) @(posedge clk);
      check_sig("jog_pos", 32'(dn ? p0 - 25 : p0 + 25), 32'(pos));
      check_sig("jog_outputs", 32'h3, 32'({p_start, permit}));
   endtask
   task automatic start_cycle(input logic [2:0] ctrl);
      park <= 1'b1;
      bus_write(`THCS_REG_CTRL, {29'h0, ctrl});
      park <= 1'b0;
      work = int'(plate) + 1;
      foreach (seq_st[i]) exp_q.push_back('{seq_st[i], work + seq_off[i]});
      if (ctrl[1]) exp_q.push_back('{THCS_SAMPLE, -1});
      exp_q.push_back('{THCS_CUTTING, -1});
      cyc <= 1'b1;
      wait_state(THCS_CONTACT);
      check_sig("contact_drive", 32'h9, 32'(drive));
      wait_state(THCS_SENSE_UP);
      check_sig("sense_drive", 32'hA, 32'(drive));
      wait_state(THCS_PLASMA);
      check_sig("plasma_out", 32'h10, 32'({p_start, drive}));
      wait_state(THCS_CUTTING);
      check_sig("permit", 32'h1, 32'(permit));
   endtask
   task automatic end_cycle;
      exp_q.push_back('{THCS_RETRACT, -1});
      exp_q.push_back('{THCS_IDLE, work + 60});
      cyc <= 1'b0;
      wait_state(THCS_IDLE);
      check_sig("queue", 32'h0, 32'(exp_q.size()));
   endtask
   task automatic complete_run;
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // Every state change is held against the expected sequence, and against the height where one is queued
   always @(posedge clk) begin
      if (rst_n && state !== last) begin
         last <= state;
         if (exp_q.size() == 0) begin
            check_sig("state", 32'h0, 32'(state));
         end else begin
            check_sig("state", 32'(exp_q[0].st), 32'(state));
            if (exp_q[0].pos >= 0) check_sig("pos", 32'(exp_q[0].pos), 32'(pos));
            void'(exp_q.pop_front());
         end
      end
   end
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      complete_run;
   end
   initial begin
      void'($urandom(65113));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      plate <= 16'h0100 + 16'($urandom_range(255));
      arc_dly <= 8'h14 + 8'($urandom_range(40));
      setpt = 120 + $urandom_range(150);
      @(posedge clk);
      check_reg("ctrl", `THCS_REG_CTRL, 32'h0);
      check_reg("status", `THCS_REG_STATUS, 32'h1);
      bus_write(`THCS_REG_STATUS, 32'hFFFF);
      check_reg("status_ro", `THCS_REG_STATUS, 32'h1);
      check_reg("unmapped", 6'h30, 32'h0);
      bus_write(`THCS_REG_CUT_H, 32'h14);
      check_reg("xfer_h", `THCS_REG_XFER_H, 32'h1E);
      foreach (dly[i]) begin
         bus_write(`THCS_REG_AVC_DLY, dly[i]);
         check_reg("avc_dly", `THCS_REG_AVC_DLY, (dly[i] > 32'h64) ? 32'h64 : dly[i]);
      end
      bus_write(`THCS_REG_PIERCE_H, 32'h28);
      bus_write(`THCS_REG_RETR_H, 32'h3C);
      bus_write(`THCS_REG_PIERCE_T, 32'h0);
      bus_write(`THCS_REG_SETPT, 32'(setpt));
      bus_write(`THCS_REG_LOCK_PCT, 32'h0A);
      // Loop on, sampled reference, head-down lock on
      start_cycle(3'h7);
      check_reg("ref", `THCS_REG_REF, 32'(100 + 5 * 21));
      offs <= 12'h00A;
      wait_move(1'b1);
      offs <= 12'h064;
      check_hold;
      offs <= 12'h000;
      wait_move(1'b0);
      inh <= 1'b1;
      offs <= 12'h00F;
      check_hold;
      inh <= 1'b0;
      wait_move(1'b1);
      end_cycle;
      // Loop off, fixed reference
      start_cycle(3'h0);
      check_reg("ref", `THCS_REG_REF, 32'(setpt));
      offs <= 12'h032;
      check_hold;
      jog(1'b0);
      jog(1'b1);
      end_cycle;
      complete_run;
   end
endmodule
`default_nettype wire
